// >>> hdl/mod_out_pkg.sv
// package for the isolated modulator bitstream output block
// assumes a single 25 MHz reference clock and a digital model of the analog input
`default_nettype none
package mod_out_pkg;
    // ==========================================================
    // widths and scaling
    // ==========================================================
    localparam int          IN_W        = 16;
    // input code standing for +320 mV full scale (clip level)
    localparam int          CLIP_CODE   = 20480;
    localparam logic [15:0] CLIP_POS    = 16'h5000;
    localparam logic [15:0] CLIP_NEG    = 16'hB000;
    localparam int          ACC_W       = 24;
    localparam logic [23:0] ACC_ZERO    = 24'h000000;
    // ==========================================================
    // over-range marker period
    // ==========================================================
    localparam int          MARK_PERIOD = 128;
    localparam logic [6:0]  MARK_LAST   = 7'h7F;
    localparam logic [6:0]  MARK_ZERO   = 7'h00;
    // ==========================================================
    // barrier carrier
    // ==========================================================
    localparam logic [1:0]  CARRIER_INIT = 2'h1;
    // sample clock limits in kHz
    localparam int          SCLK_MIN_KHZ = 5000;
    localparam int          SCLK_MAX_KHZ = 21000;

    typedef struct packed {
        logic signed [15:0] diff_code;
        logic               highside_supply_ok;
        logic               common_mode_over;
    } analog_in_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_CLIP_LOW,
        MODE_CLIP_HIGH
    } range_t;
endpackage
`default_nettype wire

// >>> hdl/mod_bitstream_out.sv
// isolated sigma-delta modulator output path: loop, clipping, fail-safe, barrier link
// assumes sample clock and analog status pins are asynchronous and are synchronised here
`default_nettype none
// Function
// - host supplies 5-21 MHz sample clock; one output bit per rising clock edge
// - second-order loop with single comparator makes one binary decision per clock
// - zero differential input gives ones half of the time
// - ones density linear with input across plus/minus 320 mV
// - at or below -320 mV stream is zero with a one every 128 clocks
// - at or above +320 mV stream is one with a zero every 128 clocks
// - high-side supply loss forces output constant low
// - common-mode overvoltage forces output constant high
// - supply loss wins over common-mode overvoltage
// - barrier carries ones as carrier bursts, zeros as silence, then demodulated
module mod_bitstream_out
    import mod_out_pkg::*;
#(
    parameter int ACC_WIDTH = ACC_W
) (
    // clock and reset
    input  wire logic                  I_REF_CLK,
    input  wire logic                  I_RESETN,
    // link from host
    input  wire logic                  I_SAMPLE_CLK,
    // high-side analog model
    input  wire mod_out_pkg::analog_in_t I_ANALOG,
    // output stream
    output logic                       O_BITSTREAM,
    output logic                       O_BIT_STROBE
);
    import mod_out_pkg::*;

    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [2:0] sclk_sync_reg, sclk_sync_next;
    analog_in_t ana_s1_reg, ana_s2_reg;
    logic       sample_edge;

    always_comb begin
        sclk_sync_next = {sclk_sync_reg[1:0], I_SAMPLE_CLK};
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN) begin
            // all ones: a sample clock that is high at release is not taken as an edge
            sclk_sync_reg <= '1;
            ana_s1_reg    <= '0;
            ana_s2_reg    <= '0;
        end else begin
            sclk_sync_reg <= sclk_sync_next;
            ana_s1_reg    <= I_ANALOG;
            ana_s2_reg    <= ana_s1_reg;
        end
    end

    // only bits 1 and 2 are read; bit 0 is the first stage
    assign sample_edge = sclk_sync_reg[1] & ~sclk_sync_reg[2];

    // ==========================================================
    // second-order loop
    // ==========================================================
    function automatic logic signed [23:0] ext(input logic signed [15:0] v);
        ext = {{(ACC_W - IN_W){v[15]}}, v};
    endfunction

    logic signed [23:0] int1_reg, int1_next, int2_reg, int2_next;
    logic               quant_reg, quant_next;
    logic signed [23:0] fb;
    range_t             range;

    always_comb begin
        if (ana_s2_reg.diff_code >= $signed(CLIP_POS))
            range = MODE_CLIP_HIGH;
        else if (ana_s2_reg.diff_code <= $signed(CLIP_NEG))
            range = MODE_CLIP_LOW;
        else
            range = MODE_NORMAL;
    end

    always_comb begin
        fb         = quant_reg ? ext(CLIP_POS) : ext(CLIP_NEG);
        int1_next  = int1_reg;
        int2_next  = int2_reg;
        quant_next = quant_reg;
        if (sample_edge) begin
            // two integrators, one comparator: density tracks input linearly
            int1_next  = int1_reg + ext(ana_s2_reg.diff_code) - fb;
            int2_next  = int2_reg + int1_next - fb;
            quant_next = ~int2_next[23];
        end
        // a clipped input winds the integrators up without bound and wraps them;
        // restart the loop from zero so it is stable again when the input returns
        if (range != MODE_NORMAL) begin
            int1_next = ACC_ZERO;
            int2_next = ACC_ZERO;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN) begin
            int1_reg  <= ACC_ZERO;
            int2_reg  <= ACC_ZERO;
            quant_reg <= 1'b0;
        end else begin
            int1_reg  <= int1_next;
            int2_reg  <= int2_next;
            quant_reg <= quant_next;
        end
    end

    // ==========================================================
    // clipping marker and fail-safe selection
    // ==========================================================
    logic [6:0] mark_cnt_reg, mark_cnt_next;
    logic       tx_bit;

    always_comb begin
        mark_cnt_next = mark_cnt_reg;
        if (range == MODE_NORMAL)
            mark_cnt_next = MARK_ZERO;
        else if (sample_edge)
            mark_cnt_next = mark_cnt_reg + 7'h01;
    end

    always_comb begin
        case (range)
            // marker on the last count of each 128-clock period
            MODE_CLIP_LOW:  tx_bit = (mark_cnt_reg == MARK_LAST);
            MODE_CLIP_HIGH: tx_bit = (mark_cnt_reg != MARK_LAST);
            MODE_NORMAL:    tx_bit = quant_reg;
            default:        tx_bit = 1'b0;
        endcase
        // fail-safe overrides; supply loss checked first so it wins
        if (!ana_s2_reg.highside_supply_ok)
            tx_bit = 1'b0;
        else if (ana_s2_reg.common_mode_over)
            tx_bit = 1'b1;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN)
            mark_cnt_reg <= MARK_ZERO;
        else
            mark_cnt_reg <= mark_cnt_next;
    end

    // ==========================================================
    // on-off keyed barrier and receiver
    // ==========================================================
    // carrier toggles while a one is sent, silent for zero; the receiver
    // compares the current and next carrier value in the same cycle, adding no cycle of latency
    logic [1:0] carrier_reg, carrier_next;
    logic       hold_bit_reg, hold_bit_next;
    logic       rx_bit;
    logic       out_reg, out_next;
    logic       strobe_reg, strobe_next;
    logic       launch_reg, launch_next;

    always_comb begin
        hold_bit_next = sample_edge ? tx_bit : hold_bit_reg;
        carrier_next  = hold_bit_reg ? ~carrier_reg : carrier_reg;
        rx_bit        = carrier_reg[0] ^ carrier_next[0];
        launch_next   = sample_edge;
        out_next      = launch_reg ? rx_bit : out_reg;
        strobe_next   = launch_reg;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN) begin
            carrier_reg  <= CARRIER_INIT;
            hold_bit_reg <= 1'b0;
            launch_reg   <= 1'b0;
            out_reg      <= 1'b0;
            strobe_reg   <= 1'b0;
        end else begin
            carrier_reg  <= carrier_next;
            hold_bit_reg <= hold_bit_next;
            launch_reg   <= launch_next;
            out_reg      <= out_next;
            strobe_reg   <= strobe_next;
        end
    end

    assign O_BITSTREAM  = out_reg;
    assign O_BIT_STROBE = strobe_reg;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    a_supply_loss_low: assert property (
        (!ana_s2_reg.highside_supply_ok && sample_edge) ##2 1 |-> ##1 !O_BITSTREAM)
        else $error("bit not low after supply loss");
    a_loss_beats_cm: assert property (
        (!ana_s2_reg.highside_supply_ok && ana_s2_reg.common_mode_over
         && sample_edge) |-> ##3 !O_BITSTREAM)
        else $error("common mode won over supply loss");
    a_cm_over_high: assert property (
        (ana_s2_reg.highside_supply_ok && ana_s2_reg.common_mode_over
         && sample_edge) |-> ##3 O_BITSTREAM)
        else $error("bit not high on common mode overvoltage");
    a_clip_low_mark: assert property (
        (range == MODE_CLIP_LOW && ana_s2_reg.highside_supply_ok
         && !ana_s2_reg.common_mode_over && sample_edge
         && mark_cnt_reg != MARK_LAST) |-> ##3 !O_BITSTREAM)
        else $error("clip low stream not zero");
    a_clip_high_mark: assert property (
        (range == MODE_CLIP_HIGH && ana_s2_reg.highside_supply_ok
         && !ana_s2_reg.common_mode_over && sample_edge
         && mark_cnt_reg == MARK_LAST) |-> ##3 !O_BITSTREAM)
        else $error("clip high marker zero missing");
    a_strobe_edge: assert property (
        sample_edge |-> ##2 O_BIT_STROBE)
        else $error("strobe not two cycles after edge");
    a_bit_stable: assert property (
        !O_BIT_STROBE |-> $stable(O_BITSTREAM))
        else $error("output moved without a launch");
    a_counter_wrap: assert property (
        (range != MODE_NORMAL && sample_edge && mark_cnt_reg == MARK_LAST)
        |=> mark_cnt_reg == MARK_ZERO)
        else $error("marker counter did not wrap");
    a_loop_decision: assert property (
        (sample_edge && range == MODE_NORMAL && ana_s2_reg.highside_supply_ok
         && !ana_s2_reg.common_mode_over) ##1 1 |-> hold_bit_reg == $past(quant_reg))
        else $error("barrier bit differs from comparator");

    c_normal_one:  cover property (O_BIT_STROBE && O_BITSTREAM && range == MODE_NORMAL);
    c_clip_marker: cover property (range == MODE_CLIP_LOW && O_BIT_STROBE && O_BITSTREAM);
    c_supply_loss: cover property (!ana_s2_reg.highside_supply_ok && O_BIT_STROBE);
    c_cm_over:     cover property (ana_s2_reg.common_mode_over && O_BITSTREAM);
endmodule
`default_nettype wire

// >>> tb/host_decimator.sv
// host-side partner: makes the sample clock and counts the returned stream
// assumes the device marks each new stream bit with a one-cycle strobe
`default_nettype none
module host_decimator (
    // clock and clear
    input  wire logic        i_clk,
    input  wire logic        i_clr,
    // stream from the device
    input  wire logic        i_bit,
    input  wire logic        i_strobe,
    // sample clock and tallies
    output logic             o_sample_clk,
    output logic [15:0]      o_n_edges,
    output logic [15:0]      o_n_bits,
    output logic [15:0]      o_n_ones
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    initial begin
        phase = 2'h0;
        o_sample_clk = 1'b0;
    end
    // 6.25 MHz with two reference cycles per phase, inside the host band
    // a plain ones tally is the cheapest decimator; markers tell clip from fail-safe
    always @(posedge i_clk) begin
        phase <= phase + 2'h1;
        o_sample_clk <= phase[1];
        if (i_clr) begin
            o_n_edges <= 16'h0000;
            o_n_bits <= 16'h0000;
            o_n_ones <= 16'h0000;
        end else begin
            if (phase[1] && !o_sample_clk) o_n_edges <= o_n_edges + 16'h0001;
            if (i_strobe) o_n_bits <= o_n_bits + 16'h0001;
            if (i_strobe && i_bit) o_n_ones <= o_n_ones + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> tb/isolated_modulator_bitstream_out_tb_top.sv
// testbench for the modulator bitstream output block
// assumes the host model supplies the sample clock and tallies the stream
`default_nettype none
module isolated_modulator_bitstream_out_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mod_out_pkg::*;
    logic I_REF_CLK = 1'b0;
    logic I_RESETN = 1'b0;
    logic clr = 1'b1;
    analog_in_t I_ANALOG = '0;
    logic O_BITSTREAM, O_BIT_STROBE, sample_clk;
    logic [15:0] n_edges, n_bits, n_ones;
    int n_fail = 0;
    int num_checks = 0;
    always #20 I_REF_CLK = ~I_REF_CLK;
    mod_bitstream_out uut (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
        .I_SAMPLE_CLK(sample_clk), .I_ANALOG(I_ANALOG),
        .O_BITSTREAM(O_BITSTREAM), .O_BIT_STROBE(O_BIT_STROBE));
    host_decimator host (.i_clk(I_REF_CLK), .i_clr(clr), .i_bit(O_BITSTREAM),
        .i_strobe(O_BIT_STROBE), .o_sample_clk(sample_clk), .o_n_edges(n_edges),
        .o_n_bits(n_bits), .o_n_ones(n_ones));
    // ==========================================================
    // compare and closing tasks
    // ==========================================================
    task automatic check_range(input logic [15:0] a, input int lo, input int hi, input string m);
        num_checks++;
        if ((a >= lo && a <= hi) !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s got %0d", $time, m, a);
        end
    endtask
    task automatic check_bit(input logic a, input logic e, input string m);
        num_checks++;
        if (a !== e) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic count_to(input int n);
        int guard;
        guard = 0;
        while (n_bits < n && guard < 20000) begin
            @(posedge I_REF_CLK);
            guard++;
        end
        if (guard >= 20000) begin
            n_fail++;
            $display("wrong value at %0t: stream stopped before %0d bits", $time, n);
        end
    endtask
    // drive one input case, let the loop settle, then tally n bits
    task automatic run(input logic [15:0] code, input logic ok, input logic cm,
                       input int n, input int lo, input int hi, input string m);
        @(posedge I_REF_CLK);
        I_ANALOG <= {code, ok, cm};
        clr <= 1'b1;
        @(posedge I_REF_CLK);
        clr <= 1'b0;
        // the clear lands one edge later; reading the tallies earlier sees the old run
        @(posedge I_REF_CLK);
        count_to(40);
        clr <= 1'b1;
        @(posedge I_REF_CLK);
        clr <= 1'b0;
        @(posedge I_REF_CLK);
        count_to(n);
        check_range(n_ones, lo, hi, m);
        // one strobe per rising sample clock edge, launched after the edge
        check_range(n_edges, n, n + 3, "bits per sample edge");
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic test_reset();
        repeat (15) @(posedge I_REF_CLK);
        check_bit(O_BITSTREAM, 1'b0, "stream in reset");
        check_bit(O_BIT_STROBE, 1'b0, "strobe in reset");
        @(posedge I_REF_CLK);
        I_RESETN <= 1'b1;
        $display("test reset done");
    endtask
    task automatic test_density();
        run(16'h0000, 1'b1, 1'b0, 512, 252, 260, "zero input density");
        run(16'h2800, 1'b1, 1'b0, 512, 378, 390, "half plus density");
        run(16'hD800, 1'b1, 1'b0, 512, 122, 134, "half minus density");
        $display("test density done");
    endtask
    task automatic test_clip();
        run(16'hB000, 1'b1, 1'b0, 512, 4, 4, "low clip markers");
        run(16'h8000, 1'b1, 1'b0, 512, 4, 4, "deep low clip markers");
        run(16'h5000, 1'b1, 1'b0, 512, 508, 508, "high clip markers");
        run(16'h7FFF, 1'b1, 1'b0, 512, 508, 508, "deep high clip markers");
        $display("test clip done");
    endtask
    task automatic test_failsafe();
        run(16'h7FFF, 1'b0, 1'b0, 512, 0, 0, "supply loss low");
        run(16'h8000, 1'b1, 1'b1, 512, 512, 512, "common mode high");
        run(16'h0000, 1'b0, 1'b1, 512, 0, 0, "supply loss wins");
        check_bit(O_BITSTREAM, 1'b0, "fail-safe level");
        $display("test failsafe done");
    endtask
    initial begin
        test_reset();
        test_density();
        test_clip();
        test_failsafe();
        print_verdict();
    end
    // whole run is about 22k cycles; twice that means a hang
    initial begin
        repeat (45000) @(posedge I_REF_CLK);
        n_fail++;
        $display("wrong value at %0t: watchdog ran out", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
